// *** verilog/sfp_pkg.sv ***
// Constants for the serial flash pin interface.
// Assumes one 200 MHz system clock samples every pin of the serial link.
package sfp_pkg;
  localparam int unsigned SFP_CLK_MHZ = 200;
  localparam int unsigned SFP_ADDR_W = 21;
  localparam int unsigned SFP_SECTOR_LSB = 12;
  localparam int unsigned SFP_BLK32_LSB = 15;
  localparam int unsigned SFP_BLK64_LSB = 16;
  localparam int unsigned SFP_SECTOR_W = SFP_ADDR_W - SFP_SECTOR_LSB;
  localparam int unsigned SFP_BLK32_W = SFP_ADDR_W - SFP_BLK32_LSB;
  localparam int unsigned SFP_BLK64_W = SFP_ADDR_W - SFP_BLK64_LSB;
  localparam int unsigned SFP_SR_QE_BIT = 6;
  localparam logic [7:0] SFP_SR_RESET = 8'h00;
  localparam logic [7:0] SFP_BYTE_ZERO = 8'h00;
  localparam logic [2:0] SFP_BIT_LAST = 3'h7;
  localparam logic [2:0] SFP_BIT_ZERO = 3'h0;
  localparam logic [2:0] SFP_BIT_STEP1 = 3'h1;
  localparam logic [2:0] SFP_BIT_STEP2 = 3'h2;
  localparam logic [2:0] SFP_BIT_STEP4 = 3'h4;
  localparam logic [1:0] SFP_WIDTH_X1 = 2'h0;
  localparam logic [1:0] SFP_WIDTH_X2 = 2'h1;
  localparam logic [1:0] SFP_WIDTH_X4 = 2'h2;
  typedef enum logic [2:0] {
    SFP_ST_IDLE = 3'b001,
    SFP_ST_SHIFT = 3'b010,
    SFP_ST_PAUSE = 3'b100
  } sfp_state_type;
endpackage : sfp_pkg

// *** verilog/sfp_flash_pins.sv ***
// Pin-level serial front end of a serial flash: lane muxing, pause, reset pin.
// Assumes the master drives the link far slower than sys_clk (link pins are sampled).
//
// Behaviour
// - Quad enable set turns the shared pause pin into data lane 3.
// - Separate-reset parts: shared pin is pause when quad disabled, select ignored.
// - Pause low while selected freezes shifting, keeping the partial command.
// - Pause low with chip select low keeps the data output tri-stated.
// - Transfer resumes at the same bit once pause returns high.
// - Reset low holds reset mode, outputs tri-stated; high means normal work.
// - Shared-pin parts: select 0 gives pause, select 1 gives reset.
// - Dual mode turns input and output pins into lanes 0 and 1.
// - Quad modes use input, output, protect and pause pins as lanes 0..3.
// - Only clock modes 0 and 3 are accepted.
// - Incoming bits are sampled on the rising clock edge.
// - Outgoing bits change from the falling clock edge.
// - Array addresses split into uniform 4 Kbyte sectors.
// - 32 Kbyte block is eight sectors, 64 Kbyte block sixteen.
// - Separate-reset parts take reset on its own pin only.
// - Chip select high deselects: outputs tri-stated, input ignored.
// - Quad enable is bit 6 of the status register.
`timescale 1ns/1ps
module sfp_flash_pins
  import sfp_pkg::*;
#(
  parameter bit DEDICATED_RESET = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_sck,
  input wire logic chip_sel_n,
  input wire logic reset_pin_n,
  input wire logic [3:0] data_lane_in,
  output logic [3:0] data_lane_out,
  output logic [3:0] data_lane_oe_n,
  input wire logic [7:0] status_reg_in,
  input wire logic pin_function_select,
  input wire logic [1:0] lane_width,
  input wire logic quad_command_mode,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  input wire logic tx_drive,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_taken,
  output logic selected,
  output logic paused,
  output logic in_reset,
  output logic mode3,
  input wire logic [SFP_ADDR_W-1:0] array_addr,
  output logic [SFP_SECTOR_W-1:0] sector_index,
  output logic [SFP_BLK32_W-1:0] block32_index,
  output logic [SFP_BLK64_W-1:0] block64_index
);
  import sfp_pkg::*;

  // Two-flop synchronisers; stage 1 is read only by stage 2.
  logic [7:0] sync1;
  logic [7:0] sync2;
  wire [7:0] raw_pins = {reset_pin_n, chip_sel_n, link_sck, 1'b0, data_lane_in};
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1 <= 8'hFF;
      sync2 <= 8'hFF;
    end
    else
    begin
      sync1 <= raw_pins;
      sync2 <= sync1;
    end
  end

  wire [3:0] lane_s = sync2[3:0];
  wire sck_s = sync2[5];
  wire cs_n_s = sync2[6];
  wire rst_pin_s = sync2[7];
  logic sck_d;
  logic cs_n_d;

  wire quad_en = status_reg_in[SFP_SR_QE_BIT];
  wire lanes_quad = quad_en || quad_command_mode;
  // Shared pin roles
  wire shared_is_pause = !lanes_quad && (DEDICATED_RESET || !pin_function_select);
  wire shared_is_reset = !lanes_quad && !DEDICATED_RESET && pin_function_select;
  wire pause_act = shared_is_pause && !lane_s[3];
  wire reset_act = DEDICATED_RESET ? !rst_pin_s : (shared_is_reset && !lane_s[3]);
  wire sel = !cs_n_s && !reset_act;
  wire sck_rise = sck_s && !sck_d;
  wire sck_fall = !sck_s && sck_d;
  wire cs_fall = !cs_n_s && cs_n_d;

  wire [1:0] eff_width = quad_command_mode ? SFP_WIDTH_X4 : lane_width;
  wire [2:0] step = (eff_width == SFP_WIDTH_X4) ? SFP_BIT_STEP4 :
                    (eff_width == SFP_WIDTH_X2) ? SFP_BIT_STEP2 : SFP_BIT_STEP1;

  sfp_state_type state;
  sfp_state_type next_state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sh;
  logic [2:0] tx_cnt;

  // MSB first: shift left, new bits enter at the bottom
  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic [1:0] w,
                                          input logic [3:0] ln);
    shift_in = (w == SFP_WIDTH_X4) ? {cur[3:0], ln} :
               (w == SFP_WIDTH_X2) ? {cur[5:0], ln[1:0]} : {cur[6:0], ln[0]};
  endfunction : shift_in

  wire [7:0] next_shreg = shift_in(shreg, eff_width, lane_s);
  wire byte_done = (bit_cnt + step) == 4'(SFP_BIT_ZERO) || (bit_cnt + step) > {1'b0, SFP_BIT_LAST};

  always_comb
  begin
    next_state = state;
    case (state)
      SFP_ST_IDLE: if (sel && cs_fall) next_state = SFP_ST_SHIFT;
      SFP_ST_SHIFT: if (!sel) next_state = SFP_ST_IDLE;
        else if (pause_act) next_state = SFP_ST_PAUSE;
      SFP_ST_PAUSE: if (!sel) next_state = SFP_ST_IDLE;
        else if (!pause_act) next_state = SFP_ST_SHIFT;
      default: next_state = SFP_ST_IDLE;
    endcase
  end

  wire shifting = (state == SFP_ST_SHIFT) && sel && !pause_act;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= SFP_ST_IDLE;
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
      shreg <= SFP_BYTE_ZERO;
      bit_cnt <= SFP_BIT_ZERO;
      rx_byte <= SFP_BYTE_ZERO;
      rx_valid <= 1'b0;
      mode3 <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
      rx_valid <= 1'b0;
      if (cs_fall)
      begin
        mode3 <= sck_s;
        bit_cnt <= SFP_BIT_ZERO;
      end
      else if (shifting && sck_rise)
      begin
        shreg <= next_shreg;
        bit_cnt <= bit_cnt + step;
        if (byte_done)
        begin
          rx_byte <= next_shreg;
          rx_valid <= 1'b1;
        end
      end
      else if (!sel)
        bit_cnt <= SFP_BIT_ZERO;
    end
  end

  // Output shifter: loads a byte, presents top bits on falling edges
  wire drive_ok = shifting && tx_drive;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_sh <= SFP_BYTE_ZERO;
      tx_cnt <= SFP_BIT_ZERO;
      tx_taken <= 1'b0;
      data_lane_out <= 4'h0;
      data_lane_oe_n <= 4'hF;
    end
    else
    begin
      tx_taken <= 1'b0;
      if (tx_load && !drive_ok)
      begin
        tx_sh <= tx_byte;
        tx_cnt <= SFP_BIT_ZERO;
      end
      else if (drive_ok && sck_fall)
      begin
        case (eff_width)
          SFP_WIDTH_X4: data_lane_out <= tx_sh[7:4];
          SFP_WIDTH_X2: data_lane_out <= {2'b00, tx_sh[7:6]};
          default: data_lane_out <= {3'b000, tx_sh[7]} << 1;
        endcase
        tx_sh <= (eff_width == SFP_WIDTH_X4) ? {tx_sh[3:0], 4'h0} :
                 (eff_width == SFP_WIDTH_X2) ? {tx_sh[5:0], 2'b00} : {tx_sh[6:0], 1'b0};
        tx_cnt <= tx_cnt + step;
        tx_taken <= ((tx_cnt + step) & SFP_BIT_LAST) == SFP_BIT_ZERO;
      end
      if (!drive_ok)
        data_lane_oe_n <= 4'hF;
      else
        case (eff_width)
          SFP_WIDTH_X4: data_lane_oe_n <= 4'h0;
          SFP_WIDTH_X2: data_lane_oe_n <= 4'hC;
          default: data_lane_oe_n <= 4'hD;
        endcase
    end
  end

  // Sector and block decode of an array address
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sector_index <= '0;
      block32_index <= '0;
      block64_index <= '0;
      selected <= 1'b0;
      paused <= 1'b0;
      in_reset <= 1'b0;
    end
    else
    begin
      sector_index <= array_addr[SFP_ADDR_W-1:SFP_SECTOR_LSB];
      block32_index <= array_addr[SFP_ADDR_W-1:SFP_BLK32_LSB];
      block64_index <= array_addr[SFP_ADDR_W-1:SFP_BLK64_LSB];
      selected <= sel;
      paused <= sel && pause_act;
      in_reset <= reset_act;
    end
  end

  AST_PAUSE_HIZ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == SFP_ST_PAUSE) |=> data_lane_oe_n == 4'hF)
    else $error("Output driven during pause");
  AST_DESEL_HIZ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sel |=> data_lane_oe_n == 4'hF)
    else $error("Output driven while deselected");
  AST_RESET_HIZ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_act |=> data_lane_oe_n == 4'hF && !selected)
    else $error("Output driven in reset");
  AST_PAUSE_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == SFP_ST_PAUSE) && sel |=> $stable(shreg) && $stable(bit_cnt))
    else $error("Partial command changed during pause");
  AST_QUAD_NO_PAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lanes_quad |-> !pause_act && !(shared_is_reset))
    else $error("Shared pin used as control in quad mode");
  AST_RX_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(shreg) |-> $past(sck_rise))
    else $error("Input sampled off the rising edge");
  AST_TX_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(tx_cnt) && !$past(tx_load) |-> $past(sck_fall))
    else $error("Output changed off the falling edge");
  AST_RESUME: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == SFP_ST_PAUSE) && sel && !pause_act |=> state == SFP_ST_SHIFT)
    else $error("Transfer did not resume");

  // Pause entry and quad drive as reusable steps
  sequence seq_hold_entry;
    (state == SFP_ST_SHIFT) && sel && pause_act;
  endsequence
  sequence seq_quad_drive;
    drive_ok && (eff_width == SFP_WIDTH_X4);
  endsequence

  AST_HOLD_ENTER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_hold_entry |=> state == SFP_ST_PAUSE)
    else $error("Pause did not freeze the transfer");
  AST_PAUSED_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel && pause_act |=> paused)
    else $error("Pause flag missing");
  AST_RX_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(rx_byte) |-> rx_valid)
    else $error("Received byte changed without a valid pulse");
  AST_MODE_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_fall |=> mode3 == $past(sck_s))
    else $error("Clock mode not taken at select");
  AST_IN_RESET_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_act |=> in_reset)
    else $error("Reset flag missing");
  AST_SECTOR_SPLIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> sector_index == $past(array_addr[SFP_ADDR_W-1:SFP_SECTOR_LSB]))
    else $error("Sector index wrong");
  AST_BLOCK64_SPLIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> block64_index == $past(array_addr[SFP_ADDR_W-1:SFP_BLK64_LSB]))
    else $error("Large block index wrong");
  AST_QUAD_OE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_quad_drive |=> data_lane_oe_n == 4'h0)
    else $error("Quad lanes not all driven");
  AST_DUAL_OE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    drive_ok && (eff_width == SFP_WIDTH_X2) |=> data_lane_oe_n == 4'hC)
    else $error("Dual lanes not driven as a pair");
  AST_DESEL_NO_RX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sel |=> !rx_valid)
    else $error("Byte received while deselected");
endmodule : sfp_flash_pins

// *** dv/sfp_master_model.sv ***
// Behavioural serial master that drives the flash link pins.
// Assumes sys_clk runs at 5 ns; the link clock half period is 16 sys_clk cycles.
`timescale 1ns/1ps
module sfp_master_model (
  input wire logic sys_clk,
  input wire logic [3:0] lane_pin,
  output logic sck,
  output logic cs_n,
  output logic [3:0] lane_drv
);
  logic idle_level;
  logic pause_n;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    pause_n = 1'b1;
    idle_level = 1'b0;
    lane_drv = 4'hc;
  end
  task automatic half();
    repeat (16) @(negedge sys_clk);
  endtask : half
  task automatic start(input logic m3);
    idle_level = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask : start
  task automatic set_pause(input logic v);
    pause_n = v;
    lane_drv[3] = v;
  endtask : set_pause
  // Unused lane 1 toggles so a stale level is never mistaken for data; unused lanes 3, 2, 0 hold pause, high, low
  task automatic bits(input logic [7:0] tx, input int w, input int n, output logic [7:0] rx);
    logic [3:0] mask;
    mask = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b0;
      lane_drv = (mask & 4'(tx >> (8 - w))) | (~mask & {pause_n, 1'b1, ~lane_drv[1], 1'b0});
      tx = tx << w;
      half();
      sck = 1'b1;
      rx = {rx[6:0], lane_pin[1]};
      half();
    end
    sck = idle_level;
  endtask : bits
  task automatic stop();
    half();
    cs_n = 1'b1;
    lane_drv = {pause_n, 1'b1, lane_drv[1:0]};
    half();
  endtask : stop
endmodule : sfp_master_model

// *** dv/tb_top.sv ***
// Self-checking bench for the flash pin front end.
// Assumes the shared pause/reset pin build; the dedicated reset pin is pulled low only once, to show it is ignored.
`timescale 1ns/1ps
module tb_top;
  import sfp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_sck, chip_sel_n, pin_function_select, quad_command_mode, tx_load, tx_drive;
  logic reset_pin_n;
  int tx_count = 0;
  logic [3:0] data_lane_in, data_lane_out, data_lane_oe_n, lane_drv;
  logic [7:0] status_reg_in, tx_byte, rx_byte, last_rx, got;
  logic [1:0] lane_width;
  logic rx_valid, tx_taken, selected, paused, in_reset, mode3;
  logic [SFP_ADDR_W-1:0] array_addr;
  logic [SFP_SECTOR_W-1:0] sector_index;
  logic [SFP_BLK32_W-1:0] block32_index;
  logic [SFP_BLK64_W-1:0] block64_index;
  int fail_count = 0;
  int checked = 0;
  int rx_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  assign data_lane_in = (~data_lane_oe_n & data_lane_out) | (data_lane_oe_n & lane_drv);
  sfp_flash_pins #(.DEDICATED_RESET(1'b0)) u_sfp_flash_pins (.sys_clk(sys_clk), .rst_n(rst_n),
    .link_sck(link_sck), .chip_sel_n(chip_sel_n), .reset_pin_n(reset_pin_n),
    .data_lane_in(data_lane_in), .data_lane_out(data_lane_out),
    .data_lane_oe_n(data_lane_oe_n), .status_reg_in(status_reg_in),
    .pin_function_select(pin_function_select), .lane_width(lane_width),
    .quad_command_mode(quad_command_mode), .tx_load(tx_load), .tx_byte(tx_byte),
    .tx_drive(tx_drive), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_taken(tx_taken),
    .selected(selected), .paused(paused), .in_reset(in_reset), .mode3(mode3),
    .array_addr(array_addr), .sector_index(sector_index),
    .block32_index(block32_index), .block64_index(block64_index));
  sfp_master_model u_sfp_master_model (.sys_clk(sys_clk), .lane_pin(data_lane_in),
    .sck(link_sck), .cs_n(chip_sel_n), .lane_drv(lane_drv));
  always @(posedge sys_clk)
    if (rx_valid === 1'b1)
    begin
      last_rx <= rx_byte;
      rx_count <= rx_count + 1;
    end
  always @(posedge sys_clk)
    if (tx_taken === 1'b1)
      tx_count <= tx_count + 1;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_rx(input int n, input logic [7:0] exp);
    int i;
    for (i = 0; i < 100 && rx_count != n; i++) @(negedge sys_clk);
    if (rx_count != n)
    begin
      fail_count++;
      summarize();
    end
    check(last_rx, exp);
  endtask : wait_rx
  task automatic t_x1_mode3();
    u_sfp_master_model.start(1'b1);
    tx_byte = 8'h96;
    tx_load = 1'b1;
    @(negedge sys_clk);
    tx_load = 1'b0;
    tx_drive = 1'b1;
    u_sfp_master_model.bits(8'h5a, 1, 8, got);
    check(mode3, 1);
    u_sfp_master_model.stop();
    tx_drive = 1'b0;
    check(got, 8'h96);
    check(tx_count, 1);
    wait_rx(1, 8'h5a);
    $display("done: single lane, clock mode 3");
  endtask : t_x1_mode3
  task automatic t_x2_mode0();
    lane_width = SFP_WIDTH_X2;
    u_sfp_master_model.start(1'b0);
    u_sfp_master_model.bits(8'hc3, 2, 4, got);
    check(mode3, 0);
    u_sfp_master_model.stop();
    wait_rx(2, 8'hc3);
    lane_width = SFP_WIDTH_X1;
    $display("done: dual lane, clock mode 0");
  endtask : t_x2_mode0
  task automatic t_quad();
    status_reg_in = 8'h40;
    lane_width = SFP_WIDTH_X4;
    u_sfp_master_model.start(1'b0);
    u_sfp_master_model.bits(8'h7e, 4, 1, got);
    check(paused, 0);
    u_sfp_master_model.bits(8'he0, 4, 1, got);
    u_sfp_master_model.stop();
    wait_rx(3, 8'h7e);
    status_reg_in = 8'h00;
    lane_width = SFP_WIDTH_X1;
    quad_command_mode = 1'b1;
    u_sfp_master_model.start(1'b0);
    u_sfp_master_model.bits(8'h18, 4, 1, got);
    check(paused, 0);
    u_sfp_master_model.bits(8'h80, 4, 1, got);
    u_sfp_master_model.stop();
    wait_rx(4, 8'h18);
    quad_command_mode = 1'b0;
    $display("done: quad command mode");
  endtask : t_quad
  task automatic t_pause();
    u_sfp_master_model.start(1'b0);
    u_sfp_master_model.bits(8'hb4, 1, 4, got);
    u_sfp_master_model.set_pause(1'b0);
    repeat (8) @(negedge sys_clk);
    check(paused, 1);
    check(data_lane_oe_n[1], 1);
    u_sfp_master_model.bits(8'hff, 1, 2, got);
    u_sfp_master_model.set_pause(1'b1);
    repeat (8) @(negedge sys_clk);
    u_sfp_master_model.bits(8'h40, 1, 4, got);
    u_sfp_master_model.stop();
    wait_rx(5, 8'hb4);
    $display("done: pause mid byte");
  endtask : t_pause
  task automatic t_reset_and_deselect();
    pin_function_select = 1'b1;
    u_sfp_master_model.set_pause(1'b0);
    repeat (8) @(negedge sys_clk);
    check(in_reset, 1);
    check(data_lane_oe_n, 4'hf);
    u_sfp_master_model.set_pause(1'b1);
    repeat (8) @(negedge sys_clk);
    check(in_reset, 0);
    reset_pin_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(in_reset, 0);
    reset_pin_n = 1'b1;
    pin_function_select = 1'b0;
    u_sfp_master_model.bits(8'hff, 1, 8, got);
    repeat (8) @(negedge sys_clk);
    check(rx_count, 5);
    check(selected, 0);
    array_addr = 21'h1e_f123;
    repeat (3) @(negedge sys_clk);
    check(sector_index, 9'h1ef);
    check(block32_index, 6'h3d);
    check(block64_index, 5'h1e);
    $display("done: reset pin, deselect, address split");
  endtask : t_reset_and_deselect
  initial
  begin
    status_reg_in = 8'h00;
    reset_pin_n = 1'b1;
    pin_function_select = 1'b0;
    lane_width = SFP_WIDTH_X1;
    quad_command_mode = 1'b0;
    tx_load = 1'b0;
    tx_byte = 8'h00;
    tx_drive = 1'b0;
    array_addr = 21'h00_0000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    t_x1_mode3();
    t_x2_mode0();
    t_quad();
    t_pause();
    t_reset_and_deselect();
    summarize();
  end
endmodule : tb_top
